/* File: shared/tb_timer_pkg.sv */
// constants shared by the time-base unit files
package tb_timer_pkg;
    localparam int unsigned count_width = 16;
    localparam int unsigned exp_width = 4;
    localparam int unsigned channel_count = 4;
    localparam logic [15:0] reload_reset = 16'hffff;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [3:0] exp_reset = 4'h0;
    localparam logic [2:0] slave_mode_off = 3'h0;
    localparam logic [2:0] slave_mode_ext1 = 3'h7;
    localparam int unsigned enable_delay_cycles = 1;
endpackage : tb_timer_pkg

/* File: verilog/prescale_divider.sv */
// power-of-two prescaler with buffered exponent
`timescale 1ns/10ps
module prescale_divider
    import tb_timer_pkg::*;
#(
    parameter int unsigned width = count_width
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic restart,
    input wire logic load,
    input wire logic [exp_width-1:0] exponent_buf,
    output logic [exp_width-1:0] exponent_active,
    output logic tick
);
    logic [width-1:0] div_count;
    logic [width-1:0] mask;
    logic div_done;

    // ratio 2**exp: tick when all low exp bits of the divider are set
    assign mask = (width'(1) << exponent_active) - width'(1);
    assign div_done = (div_count & mask) == mask;
    assign tick = run && div_done;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            div_count <= '0;
            exponent_active <= exp_reset;
        end else begin
            if (load) begin
                exponent_active <= exponent_buf;
            end
            if (restart || load || tick) begin
                div_count <= '0;
            end else if (run) begin
                div_count <= div_count + width'(1);
            end
        end
    end
endmodule : prescale_divider

/* File: verilog/pin_router.sv */
// channel pin precedence and remap for one timer instance
`timescale 1ns/10ps
module pin_router
    import tb_timer_pkg::*;
#(
    parameter int unsigned channels = channel_count
) (
    input wire logic [channels-1:0] chan_is_output,
    input wire logic [channels-1:0] chan_enabled,
    input wire logic [channels-1:0] chan_level,
    input wire logic [channels-1:0] other_level,
    input wire logic [channels-1:0] channel_remap_select,
    output logic [channels-1:0] port_a_level,
    output logic [channels-1:0] port_a_own,
    output logic [channels-1:0] port_b_level,
    output logic [channels-1:0] port_b_own
);
    genvar g;
    generate
        for (g = 0; g < channels; g++) begin : route
            wire logic drive = chan_is_output[g] && chan_enabled[g];
            wire logic to_b = channel_remap_select[g];
            // timer wins the pin only while configured as output and enabled
            assign port_a_own[g] = drive && !to_b;
            assign port_b_own[g] = drive && to_b;
            assign port_a_level[g] = port_a_own[g] ? chan_level[g] : other_level[g];
            assign port_b_level[g] = port_b_own[g] ? chan_level[g] : other_level[g];
        end
    endgenerate
endmodule : pin_router

/* File: verilog/timer_time_base_upcount.sv */
// up-counting time-base unit of a general-purpose timer
`timescale 1ns/10ps
module timer_time_base_upcount
    import tb_timer_pkg::*;
#(
    parameter int unsigned width = count_width,
    parameter int unsigned channels = channel_count,
    parameter bit is_second_timer = 1'b1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic counter_enable_bit,
    input wire logic update_disable,
    input wire logic update_request_source,
    input wire logic reload_buffer_enable,
    input wire logic update_generate,
    input wire logic slave_update_request,
    input wire logic [2:0] slave_mode_select,
    input wire logic debug_halt,
    input wire logic count_write,
    input wire logic [width-1:0] count_wdata,
    input wire logic reload_write,
    input wire logic [width-1:0] reload_wdata,
    input wire logic prescale_write,
    input wire logic [exp_width-1:0] prescale_wdata,
    input wire logic flag_clear,
    input wire logic update_interrupt_enable,
    input wire logic ext_clock_pin,
    input wire logic clock_mask_pin,
    input wire logic clock_mask_enable,
    input wire logic [channels-1:0] chan_is_output,
    input wire logic [channels-1:0] chan_enabled,
    input wire logic [channels-1:0] chan_level,
    input wire logic [channels-1:0] other_level,
    input wire logic [channels-1:0] channel_remap_select,
    output logic [width-1:0] count_reg,
    output logic [width-1:0] reload_value_reg,
    output logic [width-1:0] reload_active,
    output logic [exp_width-1:0] prescale_reg,
    output logic [exp_width-1:0] prescale_exponent,
    output logic count_active,
    output logic overflow_pulse,
    output logic update_event,
    output logic update_interrupt_flag,
    output logic update_irq,
    output logic update_generate_readback,
    output logic [channels-1:0] port_a_level,
    output logic [channels-1:0] port_a_own,
    output logic [channels-1:0] port_b_level,
    output logic [channels-1:0] port_b_own
);
    ////////////////////////////////////////////////////////////////////////////
    // external clock inputs: synchronised, used only in external clock mode
    logic ext_clk_s1;
    logic ext_clk_s2;
    logic ext_clk_s3;
    logic mask_s1;
    logic mask_s2;
    wire logic ext_mode = slave_mode_select == slave_mode_ext1;
    wire logic int_mode = slave_mode_select == slave_mode_off;
    wire logic gated_ext = ext_clk_s2 && (!clock_mask_enable || mask_s2);
    wire logic ext_edge = ext_mode && gated_ext && !ext_clk_s3;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_clk_s1 <= 1'b0;
            ext_clk_s2 <= 1'b0;
            ext_clk_s3 <= 1'b0;
            mask_s1 <= 1'b0;
            mask_s2 <= 1'b0;
        end else begin
            ext_clk_s1 <= ext_clock_pin;
            ext_clk_s2 <= ext_clk_s1;
            ext_clk_s3 <= gated_ext;
            mask_s1 <= clock_mask_pin;
            mask_s2 <= mask_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter enable and prescaler
    logic tick;
    // internal clock feeds the prescaler every cycle in internal mode while count_active is set
    wire logic presc_run = count_active && (int_mode || ext_edge);
    // debug_halt is deliberately unused by the counting path
    wire logic unused_debug = debug_halt;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_active <= 1'b0;
        end else begin
            count_active <= counter_enable_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // update event sources
    wire logic at_top = count_reg >= reload_active;
    wire logic overflow = tick && at_top;
    wire logic sw_update = update_generate || slave_update_request;
    wire logic next_update = !update_disable && (overflow || sw_update);
    wire logic flag_set = next_update && !(update_request_source && sw_update && !overflow);

    prescale_divider #(
        .width(width)
    ) u_prescale (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(presc_run),
        .restart(sw_update && !update_disable),
        .load(next_update),
        .exponent_buf(prescale_reg),
        .exponent_active(prescale_exponent),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counter and buffered registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_reg <= count_reset;
            reload_value_reg <= reload_reset;
            reload_active <= reload_reset;
            prescale_reg <= exp_reset;
        end else begin
            if (reload_write) begin
                reload_value_reg <= reload_wdata;
            end
            if (prescale_write) begin
                prescale_reg <= prescale_wdata;
            end
            if (!reload_buffer_enable) begin
                reload_active <= reload_write ? reload_wdata : reload_value_reg;
            end else if (next_update) begin
                reload_active <= reload_value_reg;
            end
            if (count_write) begin
                count_reg <= count_wdata;
            end else if (sw_update && !update_disable) begin
                count_reg <= count_reset;
            end else if (overflow) begin
                count_reg <= count_reset;
            end else if (tick) begin
                count_reg <= count_reg + width'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event strobes and sticky flag
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            update_event <= 1'b0;
            overflow_pulse <= 1'b0;
            update_interrupt_flag <= 1'b0;
        end else begin
            update_event <= next_update;
            overflow_pulse <= overflow;
            // set wins over a clear arriving in the same cycle
            if (flag_set) begin
                update_interrupt_flag <= 1'b1;
            end else if (flag_clear) begin
                update_interrupt_flag <= 1'b0;
            end
        end
    end

    assign update_irq = update_interrupt_flag && update_interrupt_enable;
    // the generate strobe is never stored, so it always reads as zero
    assign update_generate_readback = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // pins; first timer has fixed pins so remap is held at zero
    wire logic [channels-1:0] remap_eff = is_second_timer ? channel_remap_select : '0;

    pin_router #(
        .channels(channels)
    ) u_pins (
        .chan_is_output(chan_is_output),
        .chan_enabled(chan_enabled),
        .chan_level(chan_level),
        .other_level(other_level),
        .channel_remap_select(remap_eff),
        .port_a_level(port_a_level),
        .port_a_own(port_a_own),
        .port_b_level(port_b_level),
        .port_b_own(port_b_own)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    enable_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(counter_enable_bit) |=> count_active) else $error("count active late");
    no_update_disabled_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        update_disable |=> !update_event) else $error("update while disabled");
    wrap_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        overflow && !count_write && !sw_update |=> count_reg == 16'h0000) else $error("no wrap");
    overflow_update_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        overflow && !update_disable |=> update_event) else $error("overflow lost update");
    urs_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        update_request_source && update_generate && !overflow && !update_interrupt_flag && !update_disable
        |=> !update_interrupt_flag) else $error("flag set by sw update");
    flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        update_interrupt_flag && !flag_clear |=> update_interrupt_flag) else $error("flag dropped");
    prescale_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !next_update |=> prescale_exponent == $past(prescale_exponent)) else $error("ratio changed");
    reload_buffered_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        reload_buffer_enable && !next_update |=> $stable(reload_active)) else $error("reload moved");
    sw_restart_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        update_generate && !update_disable && !count_write |=> count_reg == 16'h0000) else $error("no restart");
    pin_own_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (port_a_own | port_b_own) == (chan_is_output & chan_enabled)) else $error("pin ownership");
endmodule : timer_time_base_upcount

/* File: sim/timer_time_base_upcount_tb.sv */
// self-checking bench for the up-counting time-base unit
`timescale 1ns/10ps
module timer_time_base_upcount_tb;
    import tb_timer_pkg::*;
    typedef struct packed {
        logic [3:0] is_out, en, lvl, oth, remap, a_own, b_own;
    } pin_row_t;
    localparam pin_row_t rows [4] = '{
        '{4'hf, 4'hf, 4'ha, 4'h5, 4'h0, 4'hf, 4'h0},
        '{4'hf, 4'hf, 4'h6, 4'h9, 4'hf, 4'h0, 4'hf},
        '{4'h3, 4'h5, 4'hf, 4'h0, 4'h2, 4'h1, 4'h0},
        '{4'hc, 4'hc, 4'h4, 4'hb, 4'h6, 4'h8, 4'h4}};
    // pulse bits: generate, slave, count, reload, prescale, clear
    localparam logic [5:0] p_ug = 6'h20, p_sl = 6'h10, p_cnt = 6'h08, p_rel = 6'h04, p_psc = 6'h02, p_clr = 6'h01;
    // level bits: enable, disable, request source, reload buffer, irq enable, debug halt
    localparam logic [5:0] l_en = 6'h20, l_dis = 6'h10, l_urs = 6'h08, l_rbe = 6'h04, l_ie = 6'h02, l_dbg = 6'h01;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] lv = 6'h00, lv_next = 6'h00, pulses = 6'h00;
    logic [2:0] slave_mode_select = slave_mode_off, smode_next = slave_mode_off;
    logic [15:0] wdata = 16'h0000;
    logic ext_clock_pin = 1'b0;
    logic [3:0] chan_is_output = 4'h0, chan_enabled = 4'h0, chan_level = 4'h0, other_level = 4'h0, remap = 4'h0;
    logic [15:0] count_reg, reload_value_reg, reload_active, c;
    logic [3:0] prescale_reg, prescale_exponent, port_a_level, port_a_own, port_b_level, port_b_own;
    logic count_active, overflow_pulse, update_event, update_interrupt_flag, update_irq, update_generate_readback;
    int fails = 0, n_tests = 0, n_ue = 0, n_ov = 0, n0, k;

    always #12.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (update_event === 1'b1) n_ue++;
        if (overflow_pulse === 1'b1) n_ov++;
    end

    timer_time_base_upcount dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .counter_enable_bit(lv[5]), .update_disable(lv[4]),
        .update_request_source(lv[3]), .reload_buffer_enable(lv[2]), .update_generate(pulses[5]),
        .slave_update_request(pulses[4]), .slave_mode_select(slave_mode_select), .debug_halt(lv[0]),
        .count_write(pulses[3]), .count_wdata(wdata), .reload_write(pulses[2]), .reload_wdata(wdata),
        .prescale_write(pulses[1]), .prescale_wdata(wdata[3:0]), .flag_clear(pulses[0]),
        .update_interrupt_enable(lv[1]), .ext_clock_pin(ext_clock_pin), .clock_mask_pin(1'b0),
        .clock_mask_enable(1'b0), .chan_is_output(chan_is_output), .chan_enabled(chan_enabled),
        .chan_level(chan_level), .other_level(other_level), .channel_remap_select(remap),
        .count_reg(count_reg), .reload_value_reg(reload_value_reg), .reload_active(reload_active),
        .prescale_reg(prescale_reg), .prescale_exponent(prescale_exponent), .count_active(count_active),
        .overflow_pulse(overflow_pulse), .update_event(update_event),
        .update_interrupt_flag(update_interrupt_flag), .update_irq(update_irq),
        .update_generate_readback(update_generate_readback), .port_a_level(port_a_level),
        .port_a_own(port_a_own), .port_b_level(port_b_level), .port_b_own(port_b_own));

    ////////////////////////////////////////////////////////////////////////////////
    // one rising edge: new pulses, data and levels by nba, then settle
    task drive(input logic [5:0] p, input logic [15:0] d);
        @(posedge ref_clk);
        pulses <= p;
        wdata <= d;
        lv <= lv_next;
        slave_mode_select <= smode_next;
        // pin toggles every cycle so a leak from it into the internal-clock count shows up
        ext_clock_pin <= ~ext_clock_pin;
        #1;
    endtask : drive

    task check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            {chan_is_output, chan_enabled, chan_level, other_level, remap} <= {rows[i].is_out, rows[i].en,
                rows[i].lvl, rows[i].oth, rows[i].remap};
            #1;
            check("a_own", 16'(rows[i].a_own), 16'(port_a_own));
            check("b_own", 16'(rows[i].b_own), 16'(port_b_own));
            check("a_lvl", 16'(rows[i].lvl & rows[i].a_own), 16'(port_a_level & rows[i].a_own));
            check("b_lvl", 16'(rows[i].lvl & rows[i].b_own), 16'(port_b_level & rows[i].b_own));
            check("a_oth", 16'(rows[i].oth & ~rows[i].a_own), 16'(port_a_level & ~rows[i].a_own));
        end
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        check("cnt_rst", count_reset, count_reg);
        check("rel_rst", reload_reset, reload_active);
        check("exp_rst", 16'(exp_reset), 16'(prescale_exponent));
        check("ug_rd", 16'h0000, 16'(update_generate_readback));
        drive(p_rel, 16'h0003);
        drive(p_cnt, 16'h0002);
        drive(6'h00, 16'h0000);
        check("rel_now", 16'h0003, reload_active);
        check("cnt_wr", 16'h0002, count_reg);
        lv_next = l_en | l_ie;
        drive(6'h00, 16'h0000);
        check("act_0", 16'h0000, 16'(count_active));
        drive(6'h00, 16'h0000);
        check("act_1", 16'h0001, 16'(count_active));
        check("gated", 16'h0002, count_reg);
        c = count_reg;
        k = 0;
        while (count_reg !== 16'h0000 && k < 10) begin
            c = count_reg;
            drive(6'h00, 16'h0000);
            k++;
        end
        check("wrap_top", 16'h0003, c);
        lv_next = l_ie;
        repeat (3) drive(6'h00, 16'h0000);
        check("n_ov", 16'h0001, 16'(n_ov));
        check("n_ue", 16'h0001, 16'(n_ue));
        check("irq_on", 16'h0001, 16'({update_interrupt_flag, update_irq} == 2'b11));
        lv_next = 6'h00;
        repeat (2) drive(6'h00, 16'h0000);
        check("irq_off", 16'h0002, 16'({update_interrupt_flag, update_irq}));
        drive(p_clr, 16'h0000);
        drive(6'h00, 16'h0000);
        check("clr", 16'h0000, 16'(update_interrupt_flag));
        // updates blocked: buffers must hold while the counter keeps wrapping
        lv_next = l_en | l_dis | l_rbe;
        drive(p_rel, 16'h0005);
        drive(p_psc, 16'h0002);
        drive(p_ug, 16'h0000);
        n0 = n_ue;
        c = 16'h0000;
        for (int i = 0; i < 12; i++) begin
            drive(6'h00, 16'h0000);
            if (count_reg > c) c = count_reg;
        end
        check("buf_rel", 16'h0005, reload_value_reg);
        check("buf_psc", 16'h0002, 16'(prescale_reg));
        check("hold_rel", 16'h0003, reload_active);
        check("hold_psc", 16'h0000, 16'(prescale_exponent));
        check("dis_max", 16'h0003, c);
        check("dis_ue", 16'(n0), 16'(n_ue));
        lv_next = l_en | l_rbe | l_dbg;
        k = 0;
        while (reload_active !== 16'h0005 && k < 10) begin
            drive(6'h00, 16'h0000);
            k++;
        end
        check("upd_rel", 16'h0005, reload_active);
        check("upd_psc", 16'h0002, 16'(prescale_exponent));
        for (int j = 0; j < 2; j++) begin
            c = count_reg;
            k = 0;
            while (count_reg === c && k < 40) begin
                drive(6'h00, 16'h0000);
                k++;
            end
        end
        check("div4", 16'h0004, 16'(k));
        lv_next = l_en | l_urs | l_rbe;
        // park the count at zero so no overflow can set the flag before the urs check
        drive(p_clr | p_cnt, 16'h0000);
        drive(6'h00, 16'h0000);
        n0 = n_ue;
        drive(p_ug, 16'h0000);
        drive(6'h00, 16'h0000);
        check("ug_cnt", 16'h0000, count_reg);
        check("ug_rd2", 16'h0000, 16'(update_generate_readback));
        drive(6'h00, 16'h0000);
        check("ug_ue", 16'(n0 + 1), 16'(n_ue));
        check("urs_flag", 16'h0000, 16'(update_interrupt_flag));
        check("ug_ratio", 16'h0002, 16'(prescale_exponent));
        lv_next = l_en | l_rbe;
        drive(p_ug, 16'h0000);
        repeat (2) drive(6'h00, 16'h0000);
        check("ug_flag", 16'h0001, 16'(update_interrupt_flag));
        n0 = n_ue;
        drive(p_sl, 16'h0000);
        repeat (2) drive(6'h00, 16'h0000);
        check("slave_ue", 16'(n0 + 1), 16'(n_ue));
        smode_next = 3'h1;
        repeat (3) drive(6'h00, 16'h0000);
        c = count_reg;
        repeat (12) drive(6'h00, 16'h0000);
        check("no_tick", c, count_reg);
        smode_next = slave_mode_ext1;
        repeat (4) drive(6'h00, 16'h0000);
        c = count_reg;
        repeat (16) drive(6'h00, 16'h0000);
        check("ext_tick", 16'h0001, 16'(count_reg !== c));
        report_and_stop();
    end
endmodule : timer_time_base_upcount_tb
